/* verilog/fhb_pkg.sv */
`default_nettype none
package fhb_pkg;
    localparam int unsigned DATA_W           = 32;
    localparam int unsigned RAM_ADDR_W       = 13;
    localparam int unsigned FIFO_DEPTH       = 16;
    localparam int unsigned BOOT_WORDS       = 16;
    localparam int unsigned RES_BASE         = 4096;
    localparam int unsigned PC_START         = 0;
    localparam int unsigned BOOT_WAIT_CYCLES = 65;
    localparam int unsigned CFG_VEC_MASK_BIT = 0;
    localparam logic [31:0] CFG_RESET        = 32'h0000_0000;

    // gray along idle -> cfg -> copy -> wait -> run -> vec
    typedef enum logic [2:0] {
        FHB_IDLE = 3'h0,
        FHB_CFG  = 3'h1,
        FHB_COPY = 3'h3,
        FHB_WAIT = 3'h2,
        FHB_RUN  = 3'h6,
        FHB_VEC  = 3'h7
    } fhb_state_e;
endpackage : fhb_pkg
`default_nettype wire

/* verilog/fhb_operand_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module fhb_operand_fifo #(
    parameter int unsigned W     = 32,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         wrValid,
    input  wire logic [W-1:0] wrData,
    output logic              wrReady,
    output logic              rdValid,
    output logic [W-1:0]      rdData,
    input  wire logic         rdPop
);
    localparam int unsigned IW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << IW) != DEPTH) begin : gBadDepth
            $error("fifo depth must be a power of two, at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [IW-1:0]           wrIdx;
        logic [IW-1:0]           rdIdx;
        logic [IW:0]             count;
        logic                    full;
        logic                    empty;
    } fhb_fifo_s;

    fhb_fifo_s s;
    fhb_fifo_s next_s;
    logic      push;
    logic      pop;

    always_comb begin
        next_s = s;
        push   = wrValid && !s.full;
        pop    = rdPop && !s.empty;
        if (push) begin
            next_s.mem[s.wrIdx] = wrData;
            next_s.wrIdx        = s.wrIdx + IW'(1);
        end
        if (pop) begin
            next_s.rdIdx = s.rdIdx + IW'(1);
        end
        next_s.count = s.count + (IW+1)'(push) - (IW+1)'(pop);
        next_s.full  = next_s.count == (IW+1)'(DEPTH);
        next_s.empty = next_s.count == '0;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s       <= '0;
            s.empty <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign wrReady = !s.full;
    assign rdValid = !s.empty;
    assign rdData  = s.mem[s.rdIdx];
endmodule : fhb_operand_fifo
`default_nettype wire

/* verilog/fhb_skid_buffer.sv */
`timescale 1ns/1ns
`default_nettype none
module fhb_skid_buffer #(
    parameter int unsigned W = 32
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         inValid,
    input  wire logic [W-1:0] inData,
    output logic              inReady,
    output logic              outValid,
    output logic [W-1:0]      outData,
    input  wire logic         outReady
);
    typedef struct packed {
        logic [W-1:0] d0;
        logic [W-1:0] d1;
        logic [1:0]   cnt;
        logic         inReady;
        logic         outValid;
    } fhb_skid_s;

    fhb_skid_s s;
    fhb_skid_s next_s;

    // ready is registered, so the second slot absorbs the word in flight on a stall
    always_comb begin
        next_s = s;
        if (outReady && s.outValid) begin
            next_s.d0  = s.d1;
            next_s.cnt = s.cnt - 2'h1;
        end
        if (inValid && s.inReady) begin
            if (next_s.cnt == 2'h0) begin
                next_s.d0 = inData;
            end else begin
                next_s.d1 = inData;
            end
            next_s.cnt = next_s.cnt + 2'h1;
        end
        next_s.inReady  = next_s.cnt != 2'h2;
        next_s.outValid = next_s.cnt != 2'h0;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s         <= '0;
            s.inReady <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign inReady  = s.inReady;
    assign outValid = s.outValid;
    assign outData  = s.d0;
endmodule : fhb_skid_buffer
`default_nettype wire

/* verilog/fhb_host_buffer_interface.sv */
`timescale 1ns/1ns
`default_nettype none
// Function
// - fetch instructions from shared single-port ram
// - primary operands come from the host fifo
// - write result words into shared ram
// - interrupt host when results are complete
// - bootstrap copies fifo words into shared ram
// - first bootstrap word loads configuration register
// - 65 cycles after copy, pc=0, fetch
// - vector jump obeys its configuration mask bit
// - vector jump reads address from fifo, jumps
// - vector jump costs one extra cycle when its address word already waits in the fifo
module fhb_host_buffer_interface #(
    parameter int unsigned DATA_W     = fhb_pkg::DATA_W,
    parameter int unsigned RAM_ADDR_W = fhb_pkg::RAM_ADDR_W,
    parameter int unsigned FIFO_DEPTH = fhb_pkg::FIFO_DEPTH,
    parameter int unsigned BOOT_WORDS = fhb_pkg::BOOT_WORDS,
    parameter int unsigned RES_BASE   = fhb_pkg::RES_BASE
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  hostWrValid,
    input  wire logic [DATA_W-1:0]     hostWrData,
    output logic                       hostWrReady,
    input  wire logic                  haltIn,
    input  wire logic                  intReqIn,
    input  wire logic                  vecJumpIn,
    output logic                       opValid,
    output logic [DATA_W-1:0]          opData,
    input  wire logic                  opReady,
    output logic                       instrValid,
    output logic [DATA_W-1:0]          instrData,
    output logic [RAM_ADDR_W-1:0]      instrAddr,
    input  wire logic                  instrReady,
    input  wire logic                  resValid,
    input  wire logic [DATA_W-1:0]     resData,
    input  wire logic                  resLast,
    output logic                       resReady,
    output logic                       ramEn,
    output logic                       ramWe,
    output logic [RAM_ADDR_W-1:0]      ramAddr,
    output logic [DATA_W-1:0]          ramWrData,
    input  wire logic [DATA_W-1:0]     ramRdData,
    output logic                       hostIrq,
    input  wire logic                  hostIrqAck,
    output logic [DATA_W-1:0]          configWord,
    output logic                       running
);
    localparam int unsigned WAIT_W = $clog2(fhb_pkg::BOOT_WAIT_CYCLES + 1);

    generate
        if (BOOT_WORDS < 1 || BOOT_WORDS > (1 << RAM_ADDR_W) || RES_BASE >= (1 << RAM_ADDR_W)
            || DATA_W < RAM_ADDR_W || DATA_W <= fhb_pkg::CFG_VEC_MASK_BIT) begin : gBadParam
            $error("boot length, result base or widths do not fit the shared ram");
        end
    endgenerate

    typedef struct packed {
        fhb_pkg::fhb_state_e   st;
        logic [DATA_W-1:0]     cfg;
        logic [RAM_ADDR_W-1:0] pc;
        logic                  ramEn;
        logic                  ramWe;
        logic [RAM_ADDR_W-1:0] ramAddr;
        logic [DATA_W-1:0]     ramWrData;
        logic                  capture;
        logic                  fetchBusy;
        logic                  instrValid;
        logic [DATA_W-1:0]     instrData;
        logic [RAM_ADDR_W-1:0] instrAddr;
        logic                  resReady;
        logic [RAM_ADDR_W-1:0] resPtr;
        logic                  hostIrq;
        logic [RAM_ADDR_W-1:0] bootCnt;
        logic [WAIT_W-1:0]     waitCnt;
        logic                  vecPrev;
        logic                  vecSeen;
        logic                  vecPend;
        logic                  running;
    } fhb_main_s;

    fhb_main_s         s;
    fhb_main_s         next_s;
    logic              fifoValid;
    logic [DATA_W-1:0] fifoData;
    logic              fifoPop;
    logic              bufInReady;
    logic              bufInValid;

    fhb_operand_fifo #(
        .W     (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) uFifo (
        .clk     (clk),
        .nrst    (nrst),
        .wrValid (hostWrValid),
        .wrData  (hostWrData),
        .wrReady (hostWrReady),
        .rdValid (fifoValid),
        .rdData  (fifoData),
        .rdPop   (fifoPop)
    );

    fhb_skid_buffer #(
        .W (DATA_W)
    ) uOpBuf (
        .clk      (clk),
        .nrst     (nrst),
        .inValid  (bufInValid),
        .inData   (fifoData),
        .inReady  (bufInReady),
        .outValid (opValid),
        .outData  (opData),
        .outReady (opReady)
    );

    // operands flow only while running and not diverted to a vector fetch
    assign bufInValid = fifoValid && s.st == fhb_pkg::FHB_RUN && !s.vecPend;

    always_comb begin
        next_s         = s;
        fifoPop        = bufInValid && bufInReady;
        next_s.ramEn   = 1'b0;
        next_s.ramWe   = 1'b0;
        // read data is valid the cycle after the read strobe stood on the port
        next_s.capture = s.ramEn && !s.ramWe;
        next_s.vecPrev = vecJumpIn;
        next_s.vecSeen = 1'b1;

        if (s.capture) begin
            next_s.instrData  = ramRdData;
            next_s.instrValid = 1'b1;
            next_s.fetchBusy  = 1'b0;
        end else if (s.instrValid && instrReady) begin
            next_s.instrValid = 1'b0;
        end

        // a toggle with the mask bit clear is dropped, not deferred
        if (s.vecSeen && vecJumpIn != s.vecPrev && s.cfg[fhb_pkg::CFG_VEC_MASK_BIT]
            && s.st == fhb_pkg::FHB_RUN) begin
            next_s.vecPend = 1'b1;
        end

        if (hostIrqAck) begin
            next_s.hostIrq = 1'b0;
        end

        case (s.st)
            fhb_pkg::FHB_IDLE: begin
            end
            fhb_pkg::FHB_CFG: begin
                if (fifoValid) begin
                    fifoPop        = 1'b1;
                    next_s.cfg     = fifoData;
                    next_s.bootCnt = '0;
                    next_s.st      = fhb_pkg::FHB_COPY;
                end
            end
            fhb_pkg::FHB_COPY: begin
                if (fifoValid) begin
                    fifoPop          = 1'b1;
                    next_s.ramEn     = 1'b1;
                    next_s.ramWe     = 1'b1;
                    next_s.ramAddr   = s.bootCnt;
                    next_s.ramWrData = fifoData;
                    next_s.bootCnt   = s.bootCnt + RAM_ADDR_W'(1);
                    if (s.bootCnt == RAM_ADDR_W'(BOOT_WORDS - 1)) begin
                        next_s.waitCnt = '0;
                        next_s.st      = fhb_pkg::FHB_WAIT;
                    end
                end
            end
            fhb_pkg::FHB_WAIT: begin
                next_s.waitCnt = s.waitCnt + WAIT_W'(1);
                if (s.waitCnt == WAIT_W'(fhb_pkg::BOOT_WAIT_CYCLES - 1)) begin
                    next_s.pc         = RAM_ADDR_W'(fhb_pkg::PC_START);
                    next_s.resPtr     = RAM_ADDR_W'(RES_BASE);
                    next_s.instrValid = 1'b0;
                    next_s.running    = 1'b1;
                    next_s.st         = fhb_pkg::FHB_RUN;
                end
            end
            fhb_pkg::FHB_RUN: begin
                if (s.vecPend && !s.fetchBusy && !s.capture) begin
                    next_s.st = fhb_pkg::FHB_VEC;
                end else if (resValid && s.resReady) begin
                    next_s.ramEn     = 1'b1;
                    next_s.ramWe     = 1'b1;
                    next_s.ramAddr   = s.resPtr;
                    next_s.ramWrData = resData;
                    next_s.resPtr    = s.resPtr + RAM_ADDR_W'(1);
                    if (resLast) begin
                        next_s.hostIrq = 1'b1;
                    end
                end else if (!haltIn && !s.fetchBusy && !s.capture && !next_s.instrValid) begin
                    // halt only stalls fetch; the host may hold it as long as it likes
                    next_s.ramEn     = 1'b1;
                    next_s.ramAddr   = s.pc;
                    next_s.instrAddr = s.pc;
                    next_s.pc        = s.pc + RAM_ADDR_W'(1);
                    next_s.fetchBusy = 1'b1;
                end
            end
            fhb_pkg::FHB_VEC: begin
                // one cycle here when the vector word is already waiting
                if (fifoValid) begin
                    fifoPop           = 1'b1;
                    next_s.pc         = fifoData[RAM_ADDR_W-1:0];
                    next_s.instrValid = 1'b0;
                    next_s.vecPend    = 1'b0;
                    next_s.st         = fhb_pkg::FHB_RUN;
                end
            end
            default: begin
                next_s.st = fhb_pkg::FHB_IDLE;
            end
        endcase

        if (haltIn && intReqIn && s.st != fhb_pkg::FHB_CFG && s.st != fhb_pkg::FHB_COPY) begin
            next_s.st         = fhb_pkg::FHB_CFG;
            next_s.running    = 1'b0;
            next_s.vecPend    = 1'b0;
            next_s.instrValid = 1'b0;
        end

        next_s.resReady = next_s.st == fhb_pkg::FHB_RUN && !next_s.vecPend;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s        <= '0;
            s.st     <= fhb_pkg::FHB_IDLE;
            s.cfg    <= fhb_pkg::CFG_RESET;
            s.resPtr <= RAM_ADDR_W'(RES_BASE);
        end else begin
            s <= next_s;
        end
    end

    assign instrValid = s.instrValid;
    assign instrData  = s.instrData;
    assign instrAddr  = s.instrAddr;
    assign resReady   = s.resReady;
    assign ramEn      = s.ramEn;
    assign ramWe      = s.ramWe;
    assign ramAddr    = s.ramAddr;
    assign ramWrData  = s.ramWrData;
    assign hostIrq    = s.hostIrq;
    assign configWord = s.cfg;
    assign running    = s.running;
endmodule : fhb_host_buffer_interface
`default_nettype wire

/* verification/fhb_hbi_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module fhb_hbi_properties #(
    parameter int unsigned DATA_W     = 32,
    parameter int unsigned RAM_ADDR_W = 13,
    parameter int unsigned BOOT_WORDS = 16
) (
    input wire logic                  clk,
    input wire logic                  nrst,
    input wire logic                  haltIn,
    input wire logic                  intReqIn,
    input wire logic                  opValid,
    input wire logic [DATA_W-1:0]     opData,
    input wire logic                  opReady,
    input wire logic                  instrValid,
    input wire logic [DATA_W-1:0]     instrData,
    input wire logic [RAM_ADDR_W-1:0] instrAddr,
    input wire logic                  instrReady,
    input wire logic                  resValid,
    input wire logic [DATA_W-1:0]     resData,
    input wire logic                  resLast,
    input wire logic                  resReady,
    input wire logic                  ramEn,
    input wire logic                  ramWe,
    input wire logic [RAM_ADDR_W-1:0] ramAddr,
    input wire logic [DATA_W-1:0]     ramWrData,
    input wire logic                  hostIrq,
    input wire logic                  hostIrqAck,
    input wire logic [DATA_W-1:0]     configWord,
    input wire logic                  running
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_op_hold;
        opValid && !opReady |=> opValid && $stable(opData);
    endproperty
    a_op_hold: assert property (p_op_hold) else $error("operand changed while stalled");
    // a reboot request or a vector jump legally discards the held instruction
    property p_instr_hold;
        instrValid && !instrReady && !(haltIn && intReqIn) && !configWord[0]
            |=> instrValid && $stable(instrData) && $stable(instrAddr);
    endproperty
    a_instr_hold: assert property (p_instr_hold) else $error("instruction changed while stalled");
    // a reboot request may cancel a fetch in flight, so the window excludes it
    property p_fetch_lat;
        ramEn && !ramWe && running && !configWord[0] ##1 (!intReqIn) [*2]
            |-> instrValid && instrAddr == $past(ramAddr, 2);
    endproperty
    a_fetch_lat: assert property (p_fetch_lat) else $error("fetched word late or misplaced");
    property p_res_write;
        resValid && resReady |=> ramEn && ramWe && ramWrData == $past(resData);
    endproperty
    a_res_write: assert property (p_res_write) else $error("result word not stored");
    property p_irq_set;
        resValid && resReady && resLast |=> hostIrq;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("no interrupt after last result");
    property p_irq_hold;
        hostIrq && !hostIrqAck |=> hostIrq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without ack");
    property p_boot_start;
        $rose(running) && !haltIn |-> ##[0:1] (ramEn && !ramWe && ramAddr == '0);
    endproperty
    a_boot_start: assert property (p_boot_start) else $error("run did not start at address zero");
    property p_boot_range;
        ramEn && ramWe && !running |-> ramAddr < BOOT_WORDS;
    endproperty
    a_boot_range: assert property (p_boot_range) else $error("boot copy outside image");

    c_irq: cover property ($rose(hostIrq));
    c_run: cover property ($rose(running));
    c_op_stall: cover property (opValid && !opReady ##1 opValid && opReady);
endmodule : fhb_hbi_properties

bind fhb_host_buffer_interface fhb_hbi_properties #(
    .DATA_W(DATA_W), .RAM_ADDR_W(RAM_ADDR_W), .BOOT_WORDS(BOOT_WORDS)
) chk_u (
    .clk(clk), .nrst(nrst), .haltIn(haltIn), .intReqIn(intReqIn), .opValid(opValid), .opData(opData),
    .opReady(opReady), .instrValid(instrValid), .instrData(instrData), .instrAddr(instrAddr),
    .instrReady(instrReady), .resValid(resValid), .resData(resData), .resLast(resLast),
    .resReady(resReady), .ramEn(ramEn), .ramWe(ramWe), .ramAddr(ramAddr), .ramWrData(ramWrData),
    .hostIrq(hostIrq), .hostIrqAck(hostIrqAck), .configWord(configWord), .running(running)
);
`default_nettype wire

/* verification/fhb_ram_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fhb_ram_model #(
    parameter int unsigned AW = 13,
    parameter int unsigned DW = 32
) (
    input wire logic          clk,
    input wire logic          ramEn,
    input wire logic          ramWe,
    input wire logic [AW-1:0] ramAddr,
    input wire logic [DW-1:0] ramWrData,
    output var logic [DW-1:0] ramRdData
);
    logic [DW-1:0] mem [2**AW];

    initial ramRdData = '0;

    // a read word lives one cycle, then the port shows its inverse so a sample one cycle late fails
    always @(posedge clk) begin
        if (ramEn && ramWe) begin
            mem[ramAddr] <= ramWrData;
        end
        ramRdData <= (ramEn && !ramWe) ? mem[ramAddr] : ~ramRdData;
    end
endmodule : fhb_ram_model
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int unsigned DW = fhb_pkg::DATA_W;
    localparam int unsigned AW = fhb_pkg::RAM_ADDR_W;
    localparam int unsigned BW = fhb_pkg::BOOT_WORDS;
    logic          clk, nrst, hostWrValid, hostWrReady, haltIn, intReqIn, vecJumpIn, opValid, opReady;
    logic          instrValid, instrReady, resValid, resLast, resReady, ramEn, ramWe, hostIrq, hostIrqAck, running;
    logic [DW-1:0] hostWrData, opData, instrData, resData, ramWrData, ramRdData, configWord;
    logic [AW-1:0] instrAddr, ramAddr;
    logic [DW-1:0] bootImg [BW];
    int            bad_count = 0;
    int            tests_run = 0;

    fhb_host_buffer_interface dut_u (.*);
    fhb_ram_model ram_u (.clk(clk), .ramEn(ramEn), .ramWe(ramWe), .ramAddr(ramAddr), .ramWrData(ramWrData),
                         .ramRdData(ramRdData));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bounded(input logic ok);
        if (!ok) begin
            bad_count++;
            final_report();
        end
    endtask : bounded

    // leaves valid high so back-to-back pushes never toggle it within one time step
    task automatic push(input logic [DW-1:0] w);
        int n;
        hostWrValid = 1'b1;
        hostWrData  = w;
        for (n = 0; !hostWrReady && n < 300; n++) tick();
        bounded(n < 300);
        tick();
    endtask : push

    task automatic boot(input logic [DW-1:0] cfg);
        int n;
        haltIn   = 1'b1;
        intReqIn = 1'b1;
        tick();
        intReqIn = 1'b0;
        push(cfg);
        for (int i = 0; i < BW; i++) push(bootImg[i]);
        hostWrValid = 1'b0;
        haltIn      = 1'b0;
        for (n = 0; !(ramEn && ramWe && ramAddr == AW'(BW - 1)) && n < 100; n++) tick();
        bounded(n < 100);
        for (n = 0; !running && n < 200; n++) tick();
        check(DW'(n >= 64 && n <= 67), 32'h1);
        check(configWord, cfg);
        for (int i = 0; i < BW; i++) check(ram_u.mem[i], bootImg[i]);
    endtask : boot

    task automatic fetch_seq;
        int n;
        for (int i = 0; i < 4; i++) begin
            for (n = 0; !instrValid && n < 50; n++) tick();
            bounded(n < 50);
            repeat (i) tick();
            check(DW'(instrAddr), DW'(i));
            check(instrData, bootImg[i]);
            instrReady = 1'b1;
            tick();
            instrReady = 1'b0;
        end
    endtask : fetch_seq

    task automatic operand_fill;
        int n;
        int k;
        for (n = 0; hostWrReady && n < 40; n++) begin
            hostWrValid = 1'b1;
            hostWrData  = 32'h0b00_0000 + DW'(n);
            tick();
        end
        hostWrValid = 1'b0;
        check(DW'(n >= fhb_pkg::FIFO_DEPTH && n < 40), 32'h1);
        opReady = 1'b1;
        k       = 0;
        for (int t = 0; t < 100 && k < n; t++) begin
            if (opValid) begin
                check(opData, 32'h0b00_0000 + DW'(k));
                k++;
            end
            tick();
        end
        opReady = 1'b0;
        check(DW'(k), DW'(n));
    endtask : operand_fill

    task automatic results;
        int n;
        for (int i = 0; i < 3; i++) begin
            resValid = 1'b1;
            resData  = 32'h0e00_0000 + DW'(i);
            resLast  = (i == 2);
            for (n = 0; !resReady && n < 50; n++) tick();
            bounded(n < 50);
            tick();
        end
        resValid = 1'b0;
        resLast  = 1'b0;
        tick();
        check(DW'(hostIrq), 32'h1);
        for (int i = 0; i < 3; i++) check(ram_u.mem[fhb_pkg::RES_BASE + i], 32'h0e00_0000 + DW'(i));
        hostIrqAck = 1'b1;
        tick();
        hostIrqAck = 1'b0;
        tick();
        check(DW'(hostIrq), 32'h0);
    endtask : results

    task automatic vec_masked;
        int n;
        vecJumpIn = ~vecJumpIn;
        tick();
        push(32'h0000_0005);
        hostWrValid = 1'b0;
        opReady     = 1'b1;
        for (n = 0; !opValid && n < 50; n++) tick();
        bounded(n < 50);
        check(opData, 32'h0000_0005);
        tick();
        opReady = 1'b0;
    endtask : vec_masked

    // sequential fetch cannot reach the target inside this window, only the jump can
    task automatic vec_jump;
        int n;
        instrReady = 1'b1;
        vecJumpIn  = ~vecJumpIn;
        tick();
        push(32'h0000_000e);
        hostWrValid = 1'b0;
        for (n = 0; !(instrValid && instrAddr == AW'(14)) && n < 30; n++) tick();
        bounded(n < 30);
        check(instrData, bootImg[14]);
        instrReady = 1'b0;
    endtask : vec_jump

    initial begin
        {nrst, hostWrValid, haltIn, intReqIn, vecJumpIn, opReady, instrReady} = '0;
        {resValid, resLast, hostIrqAck} = '0;
        hostWrData = '0;
        resData    = '0;
        for (int i = 0; i < BW; i++) bootImg[i] = 32'h5e00_0000 + DW'(i);
        repeat (10) tick();
        nrst = 1'b1;
        boot(32'h0000_0000);
        fetch_seq();
        operand_fill();
        results();
        vec_masked();
        boot(32'h0000_0001);
        vec_jump();
        final_report();
    end
endmodule : tb
`default_nettype wire
